// *** mstq_defs.svh ***
`ifndef MSTQ_DEFS_SVH
`define MSTQ_DEFS_SVH

// ************************************************************
// register numbers seen by the host
// ************************************************************
`define MSTQ_ADDR_STATUS   8'h00
`define MSTQ_ADDR_DEVTYPE  8'h01
`define MSTQ_ADDR_PTR_HI   8'h09
`define MSTQ_ADDR_PTR_LO   8'h0a
`define MSTQ_ADDR_EXT_DATA 8'h0b

// ************************************************************
// status register field positions
// ************************************************************
`define MSTQ_ST_PEND_HI  15
`define MSTQ_ST_PEND_LO  8
`define MSTQ_ST_LOCK_HI  7
`define MSTQ_ST_LOCK_LO  6
`define MSTQ_ST_RSVD     5
`define MSTQ_ST_READY    4
`define MSTQ_ST_ERR_HI   3
`define MSTQ_ST_ERR_LO   0

// ************************************************************
// reset values
// ************************************************************
`define MSTQ_RST_ERR     4'h0
`define MSTQ_RST_LOCK    2'h0
`define MSTQ_RST_PTR     32'h0000_0000

// lowest lock level that freezes the pointer registers
`define MSTQ_PTR_LOCK_LEVEL 2'h1

// ************************************************************
// error field codes
// ************************************************************
`define MSTQ_ERR_OK           4'h0
`define MSTQ_ERR_NOT_IMPL     4'h1
`define MSTQ_ERR_NOT_WRITABLE 4'h2
`define MSTQ_ERR_VALUE_RANGE  4'h3
`define MSTQ_ERR_PENDING      4'h4
`define MSTQ_ERR_INIT         4'h5
`define MSTQ_ERR_EXT_RANGE    4'h6
`define MSTQ_ERR_EXT_RDONLY   4'h7
`define MSTQ_ERR_GEN_FAIL     4'h8
`define MSTQ_ERR_OUT_ENABLED  4'h9
`define MSTQ_ERR_INVALID_CFG  4'ha
`define MSTQ_ERR_VENDOR       4'hf

// ************************************************************
// response status field codes
// ************************************************************
`define MSTQ_RSP_OK      2'h0
`define MSTQ_RSP_XE      2'h1
`define MSTQ_RSP_EXT     2'h2

`endif

// *** mstq_pkg.sv ***
package mstq_pkg;

  // power-up phase, one-hot
  typedef enum logic [1:0] {
    MSTQ_BOOT = 2'b01,
    MSTQ_RUN  = 2'b10
  } mstq_phase_t;

  // error field value
  typedef logic [3:0] mstq_err_t;

endpackage

// *** mstq_sync.sv ***
`timescale 1ns/1ps

// three-stage pin synchroniser; output moves once stages two and three agree
module mstq_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      levelOut
);

  logic stage1_r;  // metastable stage, read by stage2 only
  logic stage2_r;  // first settled copy
  logic stage3_r;  // second settled copy

  // shift chain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // accept a change only when the settled stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      levelOut <= 1'b0;
    end else if (stage2_r == stage3_r) begin
      levelOut <= stage3_r;
    end
  end

endmodule

// *** mstq_regbank.sv ***
`timescale 1ns/1ps
`include "mstq_defs.svh"

// ************************************************************
// status and device-type register bank
// ************************************************************

module mstq_regbank
  import mstq_pkg::*;
#(
  parameter int              STR_BYTES = 6,
  // arbitrary identification string, not a real part code
  parameter logic [8*STR_BYTES-1:0] ID_STRING = 48'h5458_4456_0000,
  parameter logic [31:0]     STR_BASE  = 32'h0000_0100
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdAddr,
  input  wire logic [15:0] cmdData,
  output logic             rspValid,
  output logic [1:0]       rspStatus,
  output logic [7:0]       rspAddr,
  output logic [15:0]      rspData,
  input  wire logic        warmupDonePin,
  input  wire logic        invalidConfig,
  input  wire logic        outputEnabled,
  input  wire logic [7:0]  pendingOps,
  input  wire logic        execFault,
  input  wire logic        vendorFault,
  input  wire logic [1:0]  lockDefault,
  output logic             moduleReady,
  output logic [1:0]       lockLevel
);

  // ************************************************************
  // declarations
  // ************************************************************
  localparam logic [15:0] STR_LEN = 16'(STR_BYTES);

  mstq_phase_t phase_r;          // boot or running
  mstq_err_t   errField_r;       // last completed command error
  mstq_err_t   err_nxt;          // error of the current command
  logic [1:0]  lockLevel_r;      // active lock level
  logic [31:0] ptr_r;            // extended access pointer
  logic [31:0] ptr_nxt;          // pointer after this command
  logic [1:0]  rspStatus_nxt;    // response status field
  logic [15:0] rspData_nxt;      // response data
  logic        warmDone;         // synchronised warm-up pin
  logic        ptrLocked;        // pointer registers frozen
  logic [31:0] ptrCand;          // pointer a write would make
  logic [31:0] strIdx;           // pointer offset into string
  logic [7:0]  idRom [STR_BYTES];// identification bytes

  // ************************************************************
  // identification string storage
  // ************************************************************
  // first character sits in the top byte of the parameter
  for (genvar i = 0; i < STR_BYTES; i++) begin : g_rom
    assign idRom[i] = ID_STRING[8*(STR_BYTES-i)-1 -: 8];
  end

  // byte fetch that reads zero beyond the string end
  function automatic logic [7:0] strByte(input logic [31:0] idx);
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < STR_BYTES; k++) begin
      if (idx == 32'(k)) begin
        b = idRom[k];
      end
    end
    return b;
  endfunction

  // ************************************************************
  // warm-up pin and readiness
  // ************************************************************
  mstq_sync u_warm_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pinIn    (warmupDonePin),
    .levelOut (warmDone)
  );

  // ready only after warm-up and with a valid configuration
  // ready flag source
  assign moduleReady = warmDone & ~invalidConfig;

  // ************************************************************
  // lock level capture
  // ************************************************************
  // saved default is sampled one clock after reset release,
  // never loaded by the asynchronous reset itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r     <= MSTQ_BOOT;
      lockLevel_r <= `MSTQ_RST_LOCK;
    end else begin
      case (phase_r)
        MSTQ_BOOT: begin
          lockLevel_r <= lockDefault;
          phase_r     <= MSTQ_RUN;
        end
        MSTQ_RUN: begin
          phase_r <= MSTQ_RUN;
        end
        default: begin
          phase_r <= MSTQ_BOOT;
        end
      endcase
    end
  end

  assign lockLevel = lockLevel_r;

  assign ptrLocked = (lockLevel_r != 2'h0) &&
                     (lockLevel_r >= `MSTQ_PTR_LOCK_LEVEL);

  // candidate pointer for a write to either half
  assign ptrCand = (cmdAddr == `MSTQ_ADDR_PTR_HI) ?
                   {cmdData, ptr_r[15:0]} : {ptr_r[31:16], cmdData};
  assign strIdx  = ptr_r - STR_BASE;

  // ************************************************************
  // command decode
  // ************************************************************
  // one command per cycle; checks in priority order, the
  // first that fires names the error
  always_comb begin
    err_nxt       = `MSTQ_ERR_OK;
    ptr_nxt       = ptr_r;
    rspData_nxt   = 16'h0000;
    rspStatus_nxt = `MSTQ_RSP_OK;
    if (cmdAddr == `MSTQ_ADDR_STATUS) begin
      if (cmdWrite) begin
        rspData_nxt = cmdData;
      end else begin
        rspData_nxt = {pendingOps, lockLevel_r, 1'b0,
                       moduleReady, errField_r};
      end
    end else if (cmdAddr != `MSTQ_ADDR_DEVTYPE &&
                 cmdAddr != `MSTQ_ADDR_PTR_HI &&
                 cmdAddr != `MSTQ_ADDR_PTR_LO &&
                 cmdAddr != `MSTQ_ADDR_EXT_DATA) begin
      err_nxt = `MSTQ_ERR_NOT_IMPL;
    end else if (vendorFault) begin
      err_nxt = `MSTQ_ERR_VENDOR;
    end else if (execFault) begin
      err_nxt = `MSTQ_ERR_GEN_FAIL;
    end else if (!warmDone || (invalidConfig && !cmdWrite)) begin
      err_nxt = `MSTQ_ERR_INIT;
    end else if (invalidConfig) begin
      err_nxt = `MSTQ_ERR_INVALID_CFG;
    end else if (pendingOps != 8'h00) begin
      err_nxt = `MSTQ_ERR_PENDING;
    end else begin
      case (cmdAddr)
        `MSTQ_ADDR_DEVTYPE: begin
          if (cmdWrite) begin
            err_nxt = `MSTQ_ERR_GEN_FAIL;
          end else begin
            rspData_nxt   = STR_LEN;
            rspStatus_nxt = `MSTQ_RSP_EXT;
            ptr_nxt       = STR_BASE;
          end
        end
        `MSTQ_ADDR_PTR_HI, `MSTQ_ADDR_PTR_LO: begin
          if (!cmdWrite) begin
            rspData_nxt = (cmdAddr == `MSTQ_ADDR_PTR_HI) ?
                          ptr_r[31:16] : ptr_r[15:0];
          end else if (ptrLocked) begin
            err_nxt = `MSTQ_ERR_NOT_WRITABLE;
          end else if (outputEnabled) begin
            err_nxt = `MSTQ_ERR_OUT_ENABLED;
          end else if (ptrCand < STR_BASE ||
                       (ptrCand - STR_BASE) > 32'(STR_LEN)) begin
            err_nxt = `MSTQ_ERR_VALUE_RANGE;
          end else begin
            rspData_nxt = cmdData;
            ptr_nxt     = ptrCand;
          end
        end
        `MSTQ_ADDR_EXT_DATA: begin
          if (cmdWrite) begin
            err_nxt = `MSTQ_ERR_EXT_RDONLY;
          end else if (ptr_r < STR_BASE ||
                       strIdx >= 32'(STR_LEN)) begin
            err_nxt = `MSTQ_ERR_EXT_RANGE;
          end else begin
            rspData_nxt = {strByte(strIdx),
                           strByte(strIdx + 32'h1)};
            ptr_nxt     = ptr_r + 32'h2;
          end
        end
        default: begin
          err_nxt = `MSTQ_ERR_NOT_IMPL;
        end
      endcase
    end
    // only listed codes exist
    // failed commands answer with zero data and the error flag
    if (err_nxt != `MSTQ_ERR_OK) begin
      rspData_nxt   = 16'h0000;
      rspStatus_nxt = `MSTQ_RSP_XE;
      ptr_nxt       = ptr_r;
    end
  end

  // ************************************************************
  // error field
  // ************************************************************
  // every command overwrites it, so a status read leaves zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      errField_r <= `MSTQ_RST_ERR;
    end else if (cmdValid) begin
      errField_r <= err_nxt;
    end
  end

  // ************************************************************
  // extended access pointer
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= `MSTQ_RST_PTR;
    end else if (cmdValid) begin
      ptr_r <= ptr_nxt;
    end
  end

  // ************************************************************
  // response
  // ************************************************************
  // answer one clock after the command, as a one-cycle pulse;
  // data fields hold until the next command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rspValid  <= 1'b0;
      rspStatus <= `MSTQ_RSP_OK;
      rspAddr   <= 8'h00;
      rspData   <= 16'h0000;
    end else begin
      rspValid <= cmdValid;
      if (cmdValid) begin
        rspStatus <= rspStatus_nxt;
        rspAddr   <= cmdAddr;
        rspData   <= rspData_nxt;
      end
    end
  end

endmodule

// *** mstq_host.sv ***
`timescale 1ns/1ps

// ************************************************************
// host command model
// ************************************************************
module mstq_host (
  input  wire logic        clk,
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [7:0]       cmdAddr,
  output logic [15:0]      cmdData,
  input  wire logic        rspValid,
  input  wire logic [1:0]  rspStatus,
  input  wire logic [15:0] rspData
);
  // idle bus at time zero
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr  = 8'h00;
    cmdData  = 16'h0000;
  end

  // one command pulse, then a bounded wait for its answer
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [1:0] st,
                      output logic [15:0] rd, output bit ok);
    int n;
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr  = a;
    cmdData  = d;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    // qualifiers scrambled so the design cannot lean on stale values
    cmdWrite = ~w;
    cmdAddr  = ~a;
    cmdData  = ~d;
    ok = 1'b0;
    st = 2'h3;
    rd = 16'hdead;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rspValid === 1'b1) begin
        ok = 1'b1;
        st = rspStatus;
        rd = rspData;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule

// *** mstq_regbank_sva.sv ***
`timescale 1ns/1ps

// ************************************************************
// port checker for the register bank
// ************************************************************
module mstq_regbank_chk
  import mstq_pkg::*;
#(
  parameter int STR_BYTES = 6
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        cmdValid,
  input wire logic        cmdWrite,
  input wire logic [7:0]  cmdAddr,
  input wire logic [15:0] cmdData,
  input wire logic        rspValid,
  input wire logic [1:0]  rspStatus,
  input wire logic [7:0]  rspAddr,
  input wire logic [15:0] rspData,
  input wire logic        invalidConfig,
  input wire logic [7:0]  pendingOps,
  input wire logic        moduleReady,
  input wire logic [1:0]  lockLevel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // status register read taken at this edge
  sequence seqStatRd;
    cmdValid && !cmdWrite && cmdAddr == 8'h00;
  endsequence
  // device-type read taken at this edge
  sequence seqTypeRd;
    cmdValid && !cmdWrite && cmdAddr == 8'h01;
  endsequence

  chk_rsp_follows: assert property (
    cmdValid |=> rspValid && rspAddr == $past(cmdAddr))
    else $error("response missing or wrong register");
  chk_rsp_only_cmd: assert property (
    rspValid |-> $past(cmdValid)) else $error("response without command");
  chk_type_length: assert property (
    seqTypeRd ##1 rspStatus != 2'h1 |-> rspStatus == 2'h2
      && rspData == 16'(STR_BYTES)) else $error("bad type length");
  chk_type_write: assert property (
    cmdValid && cmdWrite && cmdAddr == 8'h01 |=> rspStatus == 2'h1)
    else $error("type write not refused");
  chk_err_data: assert property (
    rspValid && rspStatus == 2'h1 |-> rspData == 16'h0000)
    else $error("error response carries data");
  chk_stat_echo: assert property (
    cmdValid && cmdWrite && cmdAddr == 8'h00 |=> rspStatus == 2'h0
      && rspData == $past(cmdData)) else $error("status write echo");
  chk_pend_bits: assert property (
    seqStatRd |=> rspData[15:8] == $past(pendingOps))
    else $error("pending bits wrong");
  chk_lock_rsvd: assert property (
    seqStatRd |=> rspData[7:6] == $past(lockLevel) && !rspData[5])
    else $error("lock or reserved bit wrong");
  chk_ready_bit: assert property (
    seqStatRd |=> rspData[4] == $past(moduleReady))
    else $error("ready bit wrong");
  chk_ready_cause: assert property (
    invalidConfig |-> !moduleReady) else $error("ready with bad config");
  chk_no_rsvd_code: assert property (
    seqStatRd |=> !(rspData[3:0] inside {[4'hb:4'he]}))
    else $error("reserved error code");
  // two status reads with no other command between them
  chk_clear_twice: assert property (
    seqStatRd ##1 (!cmdValid)[*2] ##1 seqStatRd |=> rspData[3:0] == 4'h0)
    else $error("error field not cleared");
endmodule

bind mstq_regbank mstq_regbank_chk #(.STR_BYTES(STR_BYTES)) u_mstq_regbank_chk (
  .clk(clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
  .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid),
  .rspStatus(rspStatus), .rspAddr(rspAddr), .rspData(rspData),
  .invalidConfig(invalidConfig), .pendingOps(pendingOps),
  .moduleReady(moduleReady), .lockLevel(lockLevel));

// *** test_mstq_regbank.sv ***
`timescale 1ns/1ps

module test_mstq_regbank
  import mstq_pkg::*;
;
  // arbitrary identification text, not a real part code
  localparam logic [47:0] ID_STR = 48'h4142_4344_0000;
  logic        clk, reset_n, warmupDonePin, invalidConfig, outputEnabled;
  logic        execFault, vendorFault, cmdValid, cmdWrite, rspValid;
  logic        moduleReady;
  logic [7:0]  cmdAddr, rspAddr, pendingOps;
  logic [15:0] cmdData, rspData, rd, lfsr;
  logic [1:0]  rspStatus, lockLevel, lockDefault, st;
  bit          ok, warmed; // warmed: bench's own view of warm-up
  int          n_mismatch, cmp_count, i;
  mstq_err_t   faultErr [6] = '{4'h4, 4'h9, 4'ha, 4'h5, 4'h8, 4'hf};

  always #2 clk = ~clk;

  mstq_regbank #(.ID_STRING(ID_STR)) u_mstq_regbank (
    .clk(clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid),
    .rspStatus(rspStatus), .rspAddr(rspAddr), .rspData(rspData),
    .warmupDonePin(warmupDonePin), .invalidConfig(invalidConfig),
    .outputEnabled(outputEnabled), .pendingOps(pendingOps),
    .execFault(execFault), .vendorFault(vendorFault),
    .lockDefault(lockDefault), .moduleReady(moduleReady),
    .lockLevel(lockLevel));
  mstq_host u_mstq_host (
    .clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .rspValid(rspValid), .rspStatus(rspStatus),
    .rspData(rspData));

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected character pair starting at byte k, earlier byte high
  function automatic logic [15:0] strPair(input int k);
    return ID_STR[47-8*k -: 16];
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one command with expected status and data
  task automatic cmd(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] es, input logic [15:0] ed);
    u_mstq_host.xfer(w, a, d, st, rd, ok);
    check({15'h0, ok}, 16'h1, "no response");
    check({14'h0, st}, {14'h0, es}, "status");
    check(rd, ed, "data");
  endtask
  // expected status word, built only from what the bench drives
  function automatic logic [15:0] statWord(input mstq_err_t e);
    return {pendingOps, lockDefault, 1'b0, warmed & ~invalidConfig, e};
  endfunction
  // status read: whole word known from the bench's own state
  task automatic errIs(input mstq_err_t e);
    cmd(1'b0, 8'h00, 16'h0, 2'h0, statWord(e));
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog: the tests need well under two thousand cycles
  initial begin
    #(4 * 20000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {warmupDonePin, invalidConfig, outputEnabled} = 3'h0;
    {execFault, vendorFault} = 2'h0;
    pendingOps = 8'h00;
    lockDefault = 2'h0;
    lfsr = 16'h002c;
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    // still warming up: commands to implemented registers other than status refused with the init error
    cmd(1'b0, 8'h01, 16'h0, 2'h1, 16'h0);
    errIs(4'h5);
    warmupDonePin = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    warmed = 1'b1;
    check({15'h0, moduleReady}, 16'h1, "ready");
    $display("test warmup done");
    // type query, string walk, overrun, then status read twice
    cmd(1'b0, 8'h01, 16'h0, 2'h2, 16'h0006);
    // pointer halves now name the string base
    cmd(1'b0, 8'h0a, 16'h0, 2'h0, 16'h0100);
    cmd(1'b0, 8'h09, 16'h0, 2'h0, 16'h0000);
    for (i = 0; i < 6; i += 2)
      cmd(1'b0, 8'h0b, 16'h0, 2'h0, strPair(i));
    cmd(1'b0, 8'h0b, 16'h0, 2'h1, 16'h0);
    errIs(4'h6);
    errIs(4'h0);
    $display("test string done");
    // register-level errors, lock level zero lets pointer writes in
    cmd(1'b0, 8'h05, 16'h0, 2'h1, 16'h0);
    errIs(4'h1);
    cmd(1'b1, 8'h01, 16'h1234, 2'h1, 16'h0);
    errIs(4'h8);
    cmd(1'b1, 8'h0b, 16'h1234, 2'h1, 16'h0);
    errIs(4'h7);
    cmd(1'b1, 8'h0a, 16'h0000, 2'h1, 16'h0);
    errIs(4'h3);
    cmd(1'b1, 8'h0a, 16'h0102, 2'h0, 16'h0102);
    cmd(1'b0, 8'h0b, 16'h0, 2'h0, strPair(2));
    $display("test register errors done");
    // one fault condition at a time, held through the status read
    for (i = 0; i < 6; i++) begin
      lfsr = lfsrNext(lfsr);
      pendingOps = (i == 0) ? (lfsr[7:0] | 8'h01) : 8'h00;
      outputEnabled = (i == 1);
      invalidConfig = (i == 2 || i == 3);
      execFault = (i == 4);
      vendorFault = (i == 5);
      cmd(i != 0 && i != 3, (i == 0) ? 8'h01 : 8'h0a, 16'h0100, 2'h1,
          16'h0);
      errIs(faultErr[i]);
    end
    {invalidConfig, outputEnabled, execFault, vendorFault} = 4'h0;
    $display("test faults done");
    // random status writes: echoed, never stored
    for (i = 0; i < 8; i++) begin
      lfsr = lfsrNext(lfsr);
      pendingOps = lfsr[15:8];
      cmd(1'b1, 8'h00, lfsr, 2'h0, lfsr);
      errIs(4'h0);
    end
    pendingOps = 8'h00;
    $display("test status writes done");
    // reset again with a saved lock level of one
    reset_n = 1'b0;
    warmed = 1'b0;
    lockDefault = 2'h1;
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    warmed = 1'b1;
    check({14'h0, lockLevel}, 16'h0001, "lock level");
    cmd(1'b1, 8'h0a, 16'h0100, 2'h1, 16'h0);
    errIs(4'h2);
    $display("test lock done");
    finish_test();
  end
endmodule
